/* core/adctp_top.v */
// converter control, result registers and temperature result path
//
// Behaviour
// - disabled converter is powered down, draws nothing
// - result is 12-bit unsigned, FFF full scale
// - transitions shifted half LSB down
// - slope times code, drop low 12 bits
// - subtract offset, keep low 12 bits
// - temperature is signed, sixteenth degree steps
// - slope bytes at FD5 and FD6
// - offset bytes at FD7 and FD8
// - constants readable only with option mapping on
// - start low-high-low; rise resets, fall starts
// - result read as low byte then high
// - 16 periods normal, 58 for temperature
// - busy high during conversion, low when valid
`timescale 1ns/10ps
`include "adctp_regs.vh"

module adctp_top (
    // clock and reset
    input  wire        clock,
    input  wire        reset,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [7:0]  reg_rdata_r,
    // calibration constants from option memory
    input  wire [15:0] cal_slope,
    input  wire [11:0] cal_offset,
    // analog converter core
    input  wire        comp_in,
    output reg  [11:0] dac_code_r,
    output wire        dac_half_lsb_shift,
    output wire        analog_power_on,
    output reg         sample_en_r,
    output wire [2:0]  input_select,
    output wire [1:0]  ref_select,
    output wire        temp_sensor_enable,
    output wire        conv_mode_select,
    // status and interrupt
    output wire        conv_busy_flag,
    output wire        conv_irq_request,
    output wire        conv_irq_enable,
    output wire        irq
);

    // ======================================================================
    // sequencer states
    localparam [1:0] ST_IDLE   = 2'h0;   // waiting for a start
    localparam [1:0] ST_SAMPLE = 2'h1;   // input tracking phase
    localparam [1:0] ST_CONV   = 2'h2;   // successive approximation

    // ======================================================================
    // software registers
    reg  [7:0]  ctrl0_r;        // start and power enable
    reg  [7:0]  ctrl1_r;        // input, reference and clock select
    reg  [7:0]  ctrl2_r;        // mode and sensor enable
    reg  [1:0]  irq_stat_r;     // sticky event bits
    reg  [1:0]  irq_mask_r;     // event enables
    reg         opt_map_r;      // option memory mapping control
    reg  [11:0] tbl_addr_r;     // table read pointer
    reg  [11:0] result_r;       // last conversion code
    reg         start_prev_r;   // start bit one cycle ago

    // ======================================================================
    // sequencer registers
    reg  [1:0]  state_r;        // sequencer state
    reg  [8:0]  div_cnt_r;      // converter clock divider
    reg  [5:0]  phase_cnt_r;    // periods left in the phase
    reg  [3:0]  bit_idx_r;      // bit under trial
    reg         temp_src_r;     // conversion is of the sensor
    reg         conv_done_r;    // one-cycle end of conversion

    // ======================================================================
    // decoded fields
    wire        start_bit;
    wire        pwr_en;
    wire [2:0]  clk_sel;
    wire [8:0]  div_lim;
    wire        adc_tick;
    wire        start_rise;
    wire        start_fall;
    wire        temp_selected;
    wire [11:0] trial_mask;
    wire [11:0] temp_val;
    wire        temp_done;
    wire [7:0]  tbl_data;
    wire [1:0]  irq_set;
    wire [1:0]  irq_clr;
    wire        wr_stat;

    assign start_bit     = ctrl0_r[`ADCTP_C0_START];
    assign pwr_en        = ctrl0_r[`ADCTP_C0_PWR];
    assign clk_sel       = ctrl1_r[`ADCTP_C1_CLK_HI:`ADCTP_C1_CLK_LO];
    assign input_select  = ctrl1_r[`ADCTP_C1_INSEL_HI:`ADCTP_C1_INSEL_LO];
    assign ref_select    = ctrl1_r[`ADCTP_C1_REF_HI:`ADCTP_C1_REF_LO];
    assign conv_mode_select   = ctrl2_r[`ADCTP_C2_MODE];
    assign temp_sensor_enable = ctrl2_r[`ADCTP_C2_TEMP_SENSOR_ENABLE] & pwr_en;
    assign temp_selected = (input_select == `ADCTP_INSEL_TEMP);

    // converter clock is the system clock divided by two to the sel plus one
    assign div_lim  = (`ADCTP_DIV_BASE << clk_sel) - `ADCTP_DIV_ONE;
    assign adc_tick = (div_cnt_r == div_lim);

    // start bit edges, seen from the stored register value
    assign start_rise = start_bit & ~start_prev_r;
    assign start_fall = ~start_bit & start_prev_r;

    // analog supply follows the enable bit alone, so no input level can
    // keep the core drawing current while it is off
    assign analog_power_on = pwr_en;

    // the comparator reference is lowered by half a code step so that each
    // transition above zero lands half a step early and the last one a step
    // and a half below the reference
    assign dac_half_lsb_shift = pwr_en;

    assign trial_mask = 12'h001 << bit_idx_r;

    assign conv_busy_flag = (state_r != ST_IDLE);

    // ======================================================================
    // interrupt logic: events set, a written one clears, set wins
    assign irq_set = {temp_done, conv_done_r};
    assign wr_stat = reg_write & (reg_addr == `ADCTP_A_IRQ_STAT);
    assign irq_clr = wr_stat ? reg_wdata[`ADCTP_IRQ_W-1:0] : `ADCTP_RST_IRQ;
    assign irq     = |(irq_stat_r & irq_mask_r);
    assign conv_irq_request = irq_stat_r[`ADCTP_IRQ_CONV];
    assign conv_irq_enable  = irq_mask_r[`ADCTP_IRQ_CONV];

    // ======================================================================
    // calibration constants appear on the last page only while mapped
    assign tbl_data =
        !opt_map_r                          ? `ADCTP_RST_BYTE :
        (tbl_addr_r == `ADCTP_LOC_SLOPE_H)  ? cal_slope[15:8] :
        (tbl_addr_r == `ADCTP_LOC_SLOPE_L)  ? cal_slope[7:0] :
        (tbl_addr_r == `ADCTP_LOC_OFS_H)    ? cal_offset[11:4] :
        (tbl_addr_r == `ADCTP_LOC_OFS_L)    ? {4'h0, cal_offset[3:0]} :
                                              `ADCTP_RST_BYTE;

    // ======================================================================
    // temperature calculation, fed when a sensor conversion ends
    adctp_temp u_temp (
        .clock       (clock),
        .reset       (reset),
        .go          (conv_done_r & temp_src_r),
        .sensor_code (result_r),
        .slope       (cal_slope),
        .offset      (cal_offset),
        .temp_r      (temp_val),
        .done_r      (temp_done)
    );

    // ======================================================================
    // software register writes
    always @(posedge clock) begin
        if (reset) begin
            ctrl0_r      <= `ADCTP_RST_BYTE;
            ctrl1_r      <= `ADCTP_RST_BYTE;
            ctrl2_r      <= `ADCTP_RST_BYTE;
            irq_mask_r   <= `ADCTP_RST_IRQ;
            opt_map_r    <= 1'b0;
            tbl_addr_r   <= `ADCTP_RST_ADDR;
            start_prev_r <= 1'b0;
        end else begin
            start_prev_r <= start_bit;
            if (reg_write) begin
                case (reg_addr)
                    `ADCTP_A_CTRL0: begin
                        // busy is status only, never stored
                        ctrl0_r <= reg_wdata & ~(8'h01 << `ADCTP_C0_BUSY);
                    end
                    `ADCTP_A_CTRL1: begin
                        ctrl1_r <= reg_wdata;
                    end
                    `ADCTP_A_CTRL2: begin
                        ctrl2_r <= reg_wdata;
                    end
                    `ADCTP_A_IRQ_MASK: begin
                        irq_mask_r <= reg_wdata[`ADCTP_IRQ_W-1:0];
                    end
                    `ADCTP_A_OPT_MAP: begin
                        opt_map_r <= reg_wdata[`ADCTP_OPT_EN];
                    end
                    `ADCTP_A_TBL_AL: begin
                        tbl_addr_r[7:0] <= reg_wdata;
                    end
                    `ADCTP_A_TBL_AH: begin
                        tbl_addr_r[11:8] <= reg_wdata[3:0];
                    end
                    default: begin
                        // read-only, unmapped, or status cleared by its own block; nothing stored here
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // sticky interrupt status
    always @(posedge clock) begin
        if (reset) begin
            irq_stat_r <= `ADCTP_RST_IRQ;
        end else begin
            // an event in the clearing cycle survives
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    // ======================================================================
    // converter clock divider, restarted by every start edge so the first
    // period of a conversion is always whole
    always @(posedge clock) begin
        if (reset) begin
            div_cnt_r <= 9'h000;
        end else if (!pwr_en || start_rise || start_fall || adc_tick) begin
            div_cnt_r <= 9'h000;
        end else begin
            div_cnt_r <= div_cnt_r + `ADCTP_DIV_ONE;
        end
    end

    // ======================================================================
    // conversion sequencer
    always @(posedge clock) begin
        if (reset) begin
            state_r     <= ST_IDLE;
            phase_cnt_r <= 6'h00;
            bit_idx_r   <= 4'h0;
            temp_src_r  <= 1'b0;
            conv_done_r <= 1'b0;
            sample_en_r <= 1'b0;
            dac_code_r  <= `ADCTP_RST_CODE;
            result_r    <= `ADCTP_RST_CODE;
        end else begin
            conv_done_r <= 1'b0;
            if (!pwr_en) begin
                // powered down: everything parked, result kept
                state_r     <= ST_IDLE;
                sample_en_r <= 1'b0;
                dac_code_r  <= `ADCTP_RST_CODE;
            end else if (start_rise) begin
                // rising step resets the converter, aborting any conversion
                state_r     <= ST_IDLE;
                sample_en_r <= 1'b0;
                dac_code_r  <= `ADCTP_RST_CODE;
            end else if (start_fall) begin
                // falling step begins sampling; sensor input needs longer
                state_r     <= ST_SAMPLE;
                sample_en_r <= 1'b1;
                temp_src_r  <= temp_selected;
                phase_cnt_r <= temp_selected ? `ADCTP_SMP_TEMP
                                             : `ADCTP_SMP_NORM;
                dac_code_r  <= `ADCTP_RST_CODE;
            end else if (adc_tick) begin
                case (state_r)
                    ST_SAMPLE: begin
                        if (phase_cnt_r == 6'h01) begin
                            // hold the input, try the top bit first
                            state_r     <= ST_CONV;
                            sample_en_r <= 1'b0;
                            bit_idx_r   <= `ADCTP_CODE_MSB;
                            phase_cnt_r <= {2'h0, `ADCTP_CNV_BITS};
                            dac_code_r  <= 12'h800;
                        end else begin
                            phase_cnt_r <= phase_cnt_r - 6'h01;
                        end
                    end
                    ST_CONV: begin
                        // comparator high keeps the trial bit
                        if (phase_cnt_r == 6'h01) begin
                            state_r     <= ST_IDLE;
                            conv_done_r <= 1'b1;
                            result_r    <= comp_in ? dac_code_r
                                                   : (dac_code_r & ~trial_mask);
                            dac_code_r  <= `ADCTP_RST_CODE;
                        end else begin
                            phase_cnt_r <= phase_cnt_r - 6'h01;
                            bit_idx_r   <= bit_idx_r - 4'h1;
                            dac_code_r  <= (comp_in ? dac_code_r
                                                    : (dac_code_r & ~trial_mask))
                                           | (trial_mask >> 1);
                        end
                    end
                    default: begin
                        // idle: nothing to time
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // temperature result storage
    reg [11:0] temp_r;   // last temperature, signed sixteenth degrees

    always @(posedge clock) begin
        if (reset) begin
            temp_r <= `ADCTP_RST_CODE;
        end else if (temp_done) begin
            temp_r <= temp_val;
        end
    end

    // ======================================================================
    // register read, data stands in the cycle after the strobe only
    always @(posedge clock) begin
        if (reset) begin
            reg_rdata_r <= `ADCTP_RST_BYTE;
        end else if (!reg_read) begin
            reg_rdata_r <= `ADCTP_RST_BYTE;
        end else begin
            case (reg_addr)
                `ADCTP_A_CTRL0: begin
                    reg_rdata_r <= ctrl0_r
                                 | ({7'h00, conv_busy_flag} << `ADCTP_C0_BUSY);
                end
                `ADCTP_A_CTRL1: begin
                    reg_rdata_r <= ctrl1_r;
                end
                `ADCTP_A_CTRL2: begin
                    reg_rdata_r <= ctrl2_r;
                end
                `ADCTP_A_RES_L: begin
                    reg_rdata_r <= result_r[7:0];
                end
                `ADCTP_A_RES_H: begin
                    reg_rdata_r <= {4'h0, result_r[11:8]};
                end
                `ADCTP_A_TEMP_L: begin
                    reg_rdata_r <= temp_r[7:0];
                end
                `ADCTP_A_TEMP_H: begin
                    // sign extended so the byte pair reads as a signed value
                    reg_rdata_r <= {{4{temp_r[11]}}, temp_r[11:8]};
                end
                `ADCTP_A_IRQ_STAT: begin
                    reg_rdata_r <= {6'h00, irq_stat_r};
                end
                `ADCTP_A_IRQ_MASK: begin
                    reg_rdata_r <= {6'h00, irq_mask_r};
                end
                `ADCTP_A_OPT_MAP: begin
                    reg_rdata_r <= {7'h00, opt_map_r};
                end
                `ADCTP_A_TBL_AL: begin
                    reg_rdata_r <= tbl_addr_r[7:0];
                end
                `ADCTP_A_TBL_AH: begin
                    reg_rdata_r <= {4'h0, tbl_addr_r[11:8]};
                end
                `ADCTP_A_TBL_DATA: begin
                    reg_rdata_r <= tbl_data;
                end
                default: begin
                    // unmapped addresses read as zero
                    reg_rdata_r <= `ADCTP_RST_BYTE;
                end
            endcase
        end
    end

endmodule

/* common/adctp_regs.vh */
// register map, field positions and timing constants of the converter result path
`ifndef ADCTP_REGS_VH
`define ADCTP_REGS_VH

// ==========================================================================
// register offsets (byte addresses on the plain register port)
`define ADCTP_A_CTRL0     8'h00
`define ADCTP_A_CTRL1     8'h01
`define ADCTP_A_CTRL2     8'h02
`define ADCTP_A_RES_L     8'h03
`define ADCTP_A_RES_H     8'h04
`define ADCTP_A_TEMP_L    8'h05
`define ADCTP_A_TEMP_H    8'h06
`define ADCTP_A_IRQ_STAT  8'h07
`define ADCTP_A_IRQ_MASK  8'h08
`define ADCTP_A_OPT_MAP   8'h09
`define ADCTP_A_TBL_AL    8'h0A
`define ADCTP_A_TBL_AH    8'h0B
`define ADCTP_A_TBL_DATA  8'h0C

// ==========================================================================
// control 0 fields
`define ADCTP_C0_START    7
`define ADCTP_C0_BUSY     6
`define ADCTP_C0_PWR      5
// control 1 fields
`define ADCTP_C1_INSEL_HI 7
`define ADCTP_C1_INSEL_LO 5
`define ADCTP_C1_REF_HI   4
`define ADCTP_C1_REF_LO   3
`define ADCTP_C1_CLK_HI   2
`define ADCTP_C1_CLK_LO   0
// control 2 fields
`define ADCTP_C2_MODE     0
`define ADCTP_C2_TEMP_SENSOR_ENABLE     1
// interrupt status and mask fields
`define ADCTP_IRQ_CONV    0
`define ADCTP_IRQ_TEMP    1
`define ADCTP_IRQ_W       2
// option map control field
`define ADCTP_OPT_EN      0

// ==========================================================================
// reset values
`define ADCTP_RST_BYTE    8'h00
`define ADCTP_RST_CODE    12'h000
`define ADCTP_RST_ADDR    12'h000
`define ADCTP_RST_IRQ     2'h0

// ==========================================================================
// converter constants
`define ADCTP_INSEL_TEMP  3'h2
`define ADCTP_SMP_NORM    6'h04
`define ADCTP_SMP_TEMP    6'h2E
`define ADCTP_CNV_BITS    4'hC
`define ADCTP_DIV_BASE    9'h002
`define ADCTP_DIV_ONE     9'h001
`define ADCTP_CODE_MSB    4'hB

// ==========================================================================
// calibration constant locations on the last program memory page
`define ADCTP_LOC_SLOPE_H 12'hFD5
`define ADCTP_LOC_SLOPE_L 12'hFD6
`define ADCTP_LOC_OFS_H   12'hFD7
`define ADCTP_LOC_OFS_L   12'hFD8

`endif

/* core/adctp_temp.v */
// temperature calculation from slope, offset and sensor code
`timescale 1ns/10ps
`include "adctp_regs.vh"

module adctp_temp (
    // clock and reset
    input  wire        clock,
    input  wire        reset,
    // request
    input  wire        go,
    input  wire [11:0] sensor_code,
    input  wire [15:0] slope,
    input  wire [11:0] offset,
    // answer
    output reg  [11:0] temp_r,
    output reg         done_r
);

    // ======================================================================
    // datapath
    wire [27:0] product;   // full width, no bits lost before the shift
    wire [15:0] shifted;   // product with its low twelve bits removed
    wire [15:0] diff;      // shifted minus offset, wraps as two's complement

    assign product = {12'h000, slope} * {16'h0000, sensor_code};
    assign shifted = product[27:12];
    assign diff    = shifted - {4'h0, offset};

    // ======================================================================
    // result register, one cycle after go
    always @(posedge clock) begin
        if (reset) begin
            temp_r <= `ADCTP_RST_CODE;
            done_r <= 1'b0;
        end else begin
            done_r <= go;
            if (go) begin
                // low twelve bits form the signed sixteenth-degree value
                temp_r <= diff[11:0];
            end
        end
    end

endmodule

/* tb/adctp_chk.sv */
// port checker for the converter result path
`timescale 1ns/10ps

module adctp_chk (
    // clock and reset
    input wire        clock,
    input wire        reset,
    // register port
    input wire        reg_read,
    input wire [7:0]  reg_rdata_r,
    // converter core
    input wire [11:0] dac_code_r,
    input wire        dac_half_lsb_shift,
    input wire        analog_power_on,
    input wire        sample_en_r,
    input wire [2:0]  input_select,
    input wire        temp_sensor_enable,
    // status
    input wire        conv_busy_flag,
    input wire        conv_irq_request,
    input wire        conv_irq_enable,
    input wire        irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // ======================================================================
    // sampling length counter, saturates so a stuck phase cannot wrap
    reg [7:0] smp_cnt_r;  // cycles spent sampling so far
    always @(posedge clock) begin
        if (reset || !sample_en_r) begin
            smp_cnt_r <= 8'h00;
        end else if (smp_cnt_r != 8'hFF) begin
            smp_cnt_r <= smp_cnt_r + 8'h01;
        end
    end

    // ======================================================================
    // conversion phase: busy held for at least eight cycles once sampling ends
    sequence conv_hold_s;
        conv_busy_flag [*8];
    endsequence

    // ======================================================================
    // assertions
    power_off_a:
    assert property (!analog_power_on && !$past(analog_power_on) && !$past(analog_power_on, 2)
        |-> dac_code_r == 12'h000 && !sample_en_r) else $error("core active while off");
    sensor_off_a:
    assert property (temp_sensor_enable |-> analog_power_on) else $error("sensor on while off");
    half_shift_a:
    assert property (dac_half_lsb_shift == analog_power_on) else $error("half step shift wrong");
    sample_len_a:
    assert property ($fell(sample_en_r) && analog_power_on
        |-> smp_cnt_r >= (input_select == 3'h2 ? 8'h5A : 8'h07)) else $error("sampling short");
    conv_len_a:
    assert property ($fell(sample_en_r) && conv_busy_flag |-> conv_hold_s)
        else $error("conversion phase short");
    first_trial_a:
    assert property ($fell(sample_en_r) && conv_busy_flag |-> ##[0:1] dac_code_r == 12'h800)
        else $error("first trial not mid scale");
    busy_sample_a:
    assert property (sample_en_r |-> conv_busy_flag) else $error("sampling without busy");
    done_flag_a:
    assert property ($fell(conv_busy_flag) && analog_power_on |-> ##[0:2] conv_irq_request)
        else $error("no done flag after busy");
    irq_level_a:
    assert property (conv_irq_request && conv_irq_enable |-> irq) else $error("irq missing");
    rdata_idle_a:
    assert property (!$past(reg_read) |-> reg_rdata_r == 8'h00) else $error("stray read data");
endmodule

bind adctp_top adctp_chk i_adctp_chk (.*);

/* tb/adctp_analog.sv */
// comparator model of the analog converter core
`timescale 1ns/10ps

module adctp_analog (
    // clock
    input  wire        clock,
    // converter core side
    input  wire [11:0] dac_code_r,
    input  wire        dac_half_lsb_shift,
    input  wire        analog_power_on,
    // analog input level, in half step units
    input  wire [12:0] vin_half,
    output wire        comp_in
);
    // ======================================================================
    reg         toggle_r;  // wandering level while unpowered
    wire [13:0] level;     // input raised by the half step offset
    wire [13:0] trial;     // trial code in half step units
    initial toggle_r = 1'b0;
    // an unpowered comparator has no valid answer, so it must not look stable
    always @(posedge clock) begin
        toggle_r <= ~toggle_r;
    end
    assign level = {1'b0, vin_half} + {13'h0000, dac_half_lsb_shift};
    assign trial = {1'b0, dac_code_r, 1'b0};
    assign comp_in = analog_power_on ? (level >= trial) : toggle_r;
endmodule

/* tb/adctp_top_tb.sv */
// self-checking bench for the converter result path
`timescale 1ns/10ps
`include "adctp_regs.vh"

module adctp_top_tb;
    // ========================================
    reg         clock, reset, reg_write, reg_read;
    reg  [7:0]  reg_addr, reg_wdata;
    reg  [15:0] cal_slope;
    reg  [11:0] cal_offset, code, tx;
    reg  [12:0] vin_half, hv;
    reg  [27:0] prod;      // full product, nothing dropped before the shift
    reg  [12:0] vt [0:6];  // input levels: five plain, two sensor
    reg  [7:0]  tb_exp [0:3];
    wire [7:0]  reg_rdata_r;
    wire [11:0] dac_code_r;
    wire [2:0]  input_select;
    wire [1:0]  ref_select;
    wire        comp_in, dac_half_lsb_shift, analog_power_on, sample_en_r;
    wire        temp_sensor_enable, conv_mode_select, conv_busy_flag;
    wire        conv_irq_request, conv_irq_enable, irq;
    integer     n_fail, tests_run, nb, i;

    adctp_top i_adctp_top (.*);
    adctp_analog i_adctp_analog (.*);

    // ========================================
    always #2 clock = ~clock;

    // compare and count; x or z never matches
    task chk(input [11:0] got, input [11:0] e);
        tests_run = tests_run + 1;
        if (got !== e) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    // one-cycle write strobe
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask
    // one-cycle read strobe, data looked at in the following cycle only
    task rd(input [7:0] a, input [7:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk({4'h0, reg_rdata_r}, {4'h0, e});
    endtask
    // configure, pulse start low-high-low, then count busy cycles;
    // busy rises one edge after the falling step lands
    task conv(input [7:0] c1, input [7:0] c2, input [12:0] v);
        vin_half <= v;
        wr(`ADCTP_A_CTRL1, c1);
        wr(`ADCTP_A_CTRL2, c2);
        wr(`ADCTP_A_CTRL0, 8'hA0);
        wr(`ADCTP_A_CTRL0, 8'h20);
        nb = 0;
        @(posedge clock);
        #1;
        while (conv_busy_flag === 1'b1 && nb < 400) begin
            @(posedge clock);
            #1;
            nb = nb + 1;
        end
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ========================================
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #(4 * 20000);
        n_fail = n_fail + 1;
        stop_test;
    end

    // ========================================
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        {reg_write, reg_read} = 2'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        cal_slope = 16'h0AB9;
        cal_offset = 12'h407;
        vin_half = 13'h0000;
        {vt[0], vt[1], vt[2], vt[3]} = {13'h0000, 13'h0001, 13'h0002, 13'h1FFD};
        {vt[4], vt[5], vt[6]} = {13'h1FFC, 13'h0A28, 13'h0C00};
        n_fail = 0;
        tests_run = 0;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        rd(`ADCTP_A_CTRL0, 8'h00);
        rd(`ADCTP_A_IRQ_STAT, 8'h00);
        rd(8'h20, 8'h00);
        wr(`ADCTP_A_CTRL0, 8'h80);
        wr(`ADCTP_A_CTRL0, 8'h00);
        repeat (3) @(posedge clock);
        #1;
        chk({10'h000, analog_power_on, conv_busy_flag}, 12'h000);
        $display("test reset and power down done");
        for (i = 0; i < 5; i = i + 1) begin
            conv(8'h18, 8'h01, vt[i]);
            hv = (vt[i] + 13'h0001) >> 1;
            code = (vt[i] >= 13'h1FFD) ? 12'hFFF : hv[11:0];
            chk({11'h000, nb >= 30 && nb <= 36}, 12'h001);
            rd(`ADCTP_A_RES_L, code[7:0]);
            rd(`ADCTP_A_RES_H, {4'h0, code[11:8]});
        end
        chk({9'h000, ref_select, conv_mode_select}, 12'h007);
        $display("test plain conversions done");
        rd(`ADCTP_A_IRQ_STAT, 8'h01);
        chk({10'h000, irq, conv_irq_request}, 12'h001);
        wr(`ADCTP_A_IRQ_MASK, 8'h01);
        chk({10'h000, irq, conv_irq_enable}, 12'h003);
        wr(`ADCTP_A_IRQ_STAT, 8'h01);
        chk({11'h000, irq}, 12'h000);
        rd(`ADCTP_A_IRQ_STAT, 8'h00);
        $display("test interrupt done");
        for (i = 5; i < 7; i = i + 1) begin
            conv(8'h40, 8'h02, vt[i]);
            code = vt[i][12:1];
            prod = cal_slope * code;
            tx = prod[23:12] - cal_offset;
            chk({11'h000, nb >= 114 && nb <= 120}, 12'h001);
            chk({11'h000, temp_sensor_enable}, 12'h001);
            // temperature lands two edges after busy falls
            @(posedge clock);
            rd(`ADCTP_A_TEMP_L, tx[7:0]);
            rd(`ADCTP_A_TEMP_H, {{4{tx[11]}}, tx[11:8]});
            rd(`ADCTP_A_IRQ_STAT, 8'h03);
            wr(`ADCTP_A_IRQ_STAT, 8'h03);
        end
        $display("test temperature done");
        {tb_exp[0], tb_exp[1]} = cal_slope;
        {tb_exp[2], tb_exp[3]} = {cal_offset[11:4], 4'h0, cal_offset[3:0]};
        wr(`ADCTP_A_OPT_MAP, 8'h00);
        wr(`ADCTP_A_TBL_AH, 8'h0F);
        wr(`ADCTP_A_TBL_AL, 8'hD5);
        rd(`ADCTP_A_TBL_DATA, 8'h00);
        wr(`ADCTP_A_OPT_MAP, 8'h01);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ADCTP_A_TBL_AL, 8'hD5 + i[7:0]);
            rd(`ADCTP_A_TBL_DATA, tb_exp[i]);
        end
        $display("test calibration table done");
        wr(`ADCTP_A_CTRL1, 8'h00);
        wr(`ADCTP_A_CTRL0, 8'hA0);
        wr(`ADCTP_A_CTRL0, 8'h20);
        repeat (4) @(posedge clock);
        wr(`ADCTP_A_CTRL0, 8'h00);
        repeat (3) @(posedge clock);
        #1;
        chk({9'h000, conv_busy_flag, analog_power_on, temp_sensor_enable}, 12'h000);
        $display("test abort by power down done");
        stop_test;
    end
endmodule
